// [design/fhas_regs.vh]
// Register map, field positions, reset values and step table for the fan slew block
`ifndef FHAS_REGS_VH
`define FHAS_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define FHAS_IDX_ACOU_ONE     7'h62
`define FHAS_IDX_ACOU_TWO     7'h63
`define FHAS_IDX_FLOOR_A      7'h64
`define FHAS_IDX_FLOOR_B      7'h65
`define FHAS_IDX_FLOOR_C      7'h66
`define FHAS_IDX_LIMIT_R1     7'h6A
`define FHAS_IDX_LIMIT_LOC    7'h6B
`define FHAS_IDX_LIMIT_R2     7'h6C
`define FHAS_IDX_HYST_R1_LOC  7'h6D
`define FHAS_IDX_HYST_R2      7'h6E
`define FHAS_IDX_STATUS       7'h70
`define FHAS_IDX_DUTY_A       7'h71
`define FHAS_IDX_DUTY_B       7'h72
`define FHAS_IDX_DUTY_C       7'h73

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FHAS_RST_ACOU         8'h00
`define FHAS_RST_FLOOR        8'h80
`define FHAS_RST_LIMIT        8'h64
`define FHAS_RST_HYST         4'h4
`define FHAS_HYST_MIN         4'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FHAS_KEEP_C_BIT       7
`define FHAS_KEEP_B_BIT       6
`define FHAS_KEEP_A_BIT       5
`define FHAS_EN_A_BIT         3
`define FHAS_EN_B_BIT         7
`define FHAS_EN_C_BIT         3

// ----------------------------------------------------------------
// Overtemp release margin, duty limits and ramp step table
// ----------------------------------------------------------------
`define FHAS_OT_HYST          8'h04
`define FHAS_DUTY_FULL        8'hFF
`define FHAS_DUTY_OFF         8'h00
`define FHAS_STEP_0           8'h01
`define FHAS_STEP_1           8'h02
`define FHAS_STEP_2           8'h03
`define FHAS_STEP_3           8'h05
`define FHAS_STEP_4           8'h08
`define FHAS_STEP_5           8'h0C
`define FHAS_STEP_6           8'h18
`define FHAS_STEP_7           8'h30

`endif

// [design/fhas_core.v]
// Fan on/off hysteresis, overtemp override and acoustic slew limiter with Wishbone registers
//
// How it works
// [RULE1] Three overtemp limit registers, remote 1, local and remote 2, reset to 0x64 (100 C).
// [RULE2] Each channel hysteresis is 1 to 15 C and resets to 4 C.
// [RULE3] Register 0x6D holds remote 1 hysteresis in bits 7:4 and local in bits 3:0.
// [RULE4] Register 0x6E holds remote 2 hysteresis in bits 7:4, reset 4 C.
// [RULE5] A running fan stays on until temperature is a hysteresis below turn-on threshold.
// [RULE6] Acoustic cfg bit 7 clear stops output c when off, set runs it at its floor duty.
// [RULE7] Acoustic cfg bit 6 clear stops output b when off, set runs it at its floor duty.
// [RULE8] Acoustic cfg bit 5 clear stops output a when off, set runs it at its floor duty.
// [RULE9] An output kept at its floor ignores hysteresis when temperature falls.
// [RULE10] Without enhancement a new calculated duty is applied at once.
// [RULE11] With enhancement the duty change per update is limited.
// [RULE12] With enhancement the duty moves a fixed step toward the target, up or down.
// [RULE13] Enhancement is enabled per output, whatever channel drives it.
// [RULE14] Any temperature above its limit forces full duty until 4 C below that limit; the code holds it until more than 4 C below.
// [RULE15] Acoustic cfg one bit 3 enables enhancement on output a.
// [RULE16] A 3-bit code per output picks a step of 1, 2, 3, 5, 8, 12, 24 or 48 slots.
// [RULE17] Each output keeps an on/off state; once off it waits for temp above threshold.
`include "fhas_regs.vh"
`default_nettype none

module fhas_core (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [8:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Temperature readings and turn-on thresholds per channel
    input  wire [7:0]  temp_r1_i,
    input  wire [7:0]  temp_loc_i,
    input  wire [7:0]  temp_r2_i,
    input  wire [7:0]  tmin_r1_i,
    input  wire [7:0]  tmin_loc_i,
    input  wire [7:0]  tmin_r2_i,
    // Channel feeding each output: 0 remote 1, 1 local, 2 remote 2
    input  wire [1:0]  chan_a_i,
    input  wire [1:0]  chan_b_i,
    input  wire [1:0]  chan_c_i,
    // Calculated target duty per output and update strobe
    input  wire [7:0]  target_a_i,
    input  wire [7:0]  target_b_i,
    input  wire [7:0]  target_c_i,
    input  wire        update_i,
    // Applied duty cycles and overtemp flag
    output wire [7:0]  fan_output_a_o,
    output wire [7:0]  fan_output_b_o,
    output wire [7:0]  fan_output_c_o,
    output reg         overtemp_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg  [7:0] acou_one_r;
    reg  [7:0] acou_two_r;
    reg  [7:0] floor_r      [0:2];
    reg  [7:0] limit_r      [0:2];
    reg  [3:0] hyst_r       [0:2];
    reg  [7:0] duty_r       [0:2];
    reg  [2:0] on_r;

    wire [7:0] temp_w       [0:2];
    wire [7:0] tmin_w       [0:2];
    wire [7:0] tgt_w        [0:2];
    wire [1:0] chan_w       [0:2];
    wire [6:0] idx_w;
    wire       req_w;
    wire       wr_w;

    // One loop index per process; a shared index re-wakes the comb blocks
    integer    i_ot;
    integer    i_fan;
    integer    i_duty;
    integer    i_cfg;

    assign temp_w[0] = temp_r1_i;
    assign temp_w[1] = temp_loc_i;
    assign temp_w[2] = temp_r2_i;
    assign tmin_w[0] = tmin_r1_i;
    assign tmin_w[1] = tmin_loc_i;
    assign tmin_w[2] = tmin_r2_i;
    assign tgt_w[0]  = target_a_i;
    assign tgt_w[1]  = target_b_i;
    assign tgt_w[2]  = target_c_i;
    assign chan_w[0] = chan_a_i;
    assign chan_w[1] = chan_b_i;
    assign chan_w[2] = chan_c_i;

    assign fan_output_a_o = duty_r[0];
    assign fan_output_b_o = duty_r[1];
    assign fan_output_c_o = duty_r[2];

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Step code to slot count
    function [7:0] step_of;
        input [2:0] code;
        begin
            case (code) // [RULE16]
                3'h0:    step_of = `FHAS_STEP_0;
                3'h1:    step_of = `FHAS_STEP_1;
                3'h2:    step_of = `FHAS_STEP_2;
                3'h3:    step_of = `FHAS_STEP_3;
                3'h4:    step_of = `FHAS_STEP_4;
                3'h5:    step_of = `FHAS_STEP_5;
                3'h6:    step_of = `FHAS_STEP_6;
                default: step_of = `FHAS_STEP_7;
            endcase
        end
    endfunction

    // Zero written to a hysteresis field would defeat the chatter guard
    function [3:0] hyst_fix;
        input [3:0] v;
        begin
            hyst_fix = (v == 4'h0) ? `FHAS_HYST_MIN : v; // [RULE2]
        end
    endfunction

    // Channel index clamp: code 3 falls back to remote 1
    function [1:0] chan_fix;
        input [1:0] c;
        begin
            chan_fix = (c == 2'h3) ? 2'h0 : c;
        end
    endfunction

    // One slew step from cur toward tgt, never overshooting
    function [7:0] slew;
        input [7:0] cur;
        input [7:0] tgt;
        input [7:0] step;
        reg   [8:0] up;
        begin
            up = {1'b0, cur} + {1'b0, step};
            if (tgt > cur) begin
                slew = (up > {1'b0, tgt}) ? tgt : up[7:0]; // [RULE12]
            end else if (tgt < cur) begin
                slew = (cur < step || (cur - step) < tgt) ? tgt : cur - step; // [RULE12]
            end else begin
                slew = cur;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Per-output configuration decode
    // ------------------------------------------------------------
    // Each output has its own enable and step, independent of channel
    reg        en_w   [0:2];
    reg  [2:0] code_w [0:2];
    reg        keep_w [0:2];

    always @* begin
        en_w[0]   = acou_one_r[`FHAS_EN_A_BIT]; // [RULE15] [RULE13]
        en_w[1]   = acou_two_r[`FHAS_EN_B_BIT]; // [RULE13]
        en_w[2]   = acou_two_r[`FHAS_EN_C_BIT]; // [RULE13]
        code_w[0] = acou_one_r[2:0];
        code_w[1] = acou_two_r[6:4];
        code_w[2] = acou_two_r[2:0];
        keep_w[0] = acou_one_r[`FHAS_KEEP_A_BIT]; // [RULE8]
        keep_w[1] = acou_one_r[`FHAS_KEEP_B_BIT]; // [RULE7]
        keep_w[2] = acou_one_r[`FHAS_KEEP_C_BIT]; // [RULE6]
    end

    // ------------------------------------------------------------
    // Overtemp detection
    // ------------------------------------------------------------
    // Set when any channel is above its limit, released only when
    // every channel is more than 4 C below its own limit
    reg ot_over_w;
    reg ot_near_w;

    always @* begin
        ot_over_w = 1'b0;
        ot_near_w = 1'b0;
        for (i_ot = 0; i_ot < 3; i_ot = i_ot + 1) begin
            if (temp_w[i_ot] > limit_r[i_ot]) begin
                ot_over_w = 1'b1; // [RULE14]
            end
            if ({1'b0, temp_w[i_ot]} + {1'b0, `FHAS_OT_HYST} >= {1'b0, limit_r[i_ot]}) begin
                ot_near_w = 1'b1; // [RULE14]
            end
        end
    end

    // ------------------------------------------------------------
    // Fan state and duty update
    // ------------------------------------------------------------
    // Off state: hysteresis-gated for stopping fans; a floor-keeping
    // fan simply drops to its floor once below threshold
    reg  [2:0] on_nxt;
    reg  [7:0] calc_w [0:2];
    reg  [7:0] t_w;
    reg  [7:0] m_w;
    reg  [3:0] h_w;
    reg  [1:0] c_w;

    always @* begin
        t_w = 8'h00;
        m_w = 8'h00;
        h_w = 4'h0;
        c_w = 2'h0;
        for (i_fan = 0; i_fan < 3; i_fan = i_fan + 1) begin
            c_w = chan_fix(chan_w[i_fan]);
            t_w = temp_w[c_w];
            m_w = tmin_w[c_w];
            h_w = hyst_r[c_w];
            on_nxt[i_fan] = on_r[i_fan];
            if (t_w > m_w) begin
                on_nxt[i_fan] = 1'b1; // [RULE17]
            end else if ({1'b0, t_w} + {5'h00, h_w} <= {1'b0, m_w}) begin
                on_nxt[i_fan] = 1'b0; // [RULE5]
            end
            if (keep_w[i_fan]) begin
                calc_w[i_fan] = (t_w > m_w) ? tgt_w[i_fan] : floor_r[i_fan]; // [RULE9]
            end else begin
                calc_w[i_fan] = on_nxt[i_fan] ? tgt_w[i_fan] : `FHAS_DUTY_OFF; // [RULE5]
            end
        end
    end

    // Duty registers only move on an update strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            on_r       <= 3'h0;
            overtemp_o <= 1'b0;
            for (i_duty = 0; i_duty < 3; i_duty = i_duty + 1) begin
                duty_r[i_duty] <= `FHAS_DUTY_OFF;
            end
        end else if (update_i) begin
            on_r <= on_nxt;
            if (ot_over_w || (overtemp_o && ot_near_w)) begin
                overtemp_o <= 1'b1; // [RULE14]
                for (i_duty = 0; i_duty < 3; i_duty = i_duty + 1) begin
                    duty_r[i_duty] <= `FHAS_DUTY_FULL; // [RULE14]
                end
            end else begin
                overtemp_o <= 1'b0;
                for (i_duty = 0; i_duty < 3; i_duty = i_duty + 1) begin
                    if (en_w[i_duty]) begin
                        duty_r[i_duty] <= slew(duty_r[i_duty], calc_w[i_duty],
                                               step_of(code_w[i_duty])); // [RULE11]
                    end else begin
                        duty_r[i_duty] <= calc_w[i_duty]; // [RULE10]
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // Word index from byte address; ack is one registered cycle
    assign idx_w = wb_adr_i[8:2];
    assign req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_w  = req_w & wb_we_i & wb_sel_i[0];

    // Register writes, only byte lane 0 carries data
    always @(posedge clk_i) begin
        if (rst_i) begin
            acou_one_r <= `FHAS_RST_ACOU;
            acou_two_r <= `FHAS_RST_ACOU;
            for (i_cfg = 0; i_cfg < 3; i_cfg = i_cfg + 1) begin
                floor_r[i_cfg] <= `FHAS_RST_FLOOR;
                limit_r[i_cfg] <= `FHAS_RST_LIMIT; // [RULE1]
                hyst_r[i_cfg]  <= `FHAS_RST_HYST;  // [RULE2] [RULE4]
            end
        end else if (wr_w) begin
            case (idx_w)
                `FHAS_IDX_ACOU_ONE:    acou_one_r <= wb_dat_i[7:0];
                `FHAS_IDX_ACOU_TWO:    acou_two_r <= wb_dat_i[7:0];
                `FHAS_IDX_FLOOR_A:     floor_r[0] <= wb_dat_i[7:0];
                `FHAS_IDX_FLOOR_B:     floor_r[1] <= wb_dat_i[7:0];
                `FHAS_IDX_FLOOR_C:     floor_r[2] <= wb_dat_i[7:0];
                `FHAS_IDX_LIMIT_R1:    limit_r[0] <= wb_dat_i[7:0]; // [RULE1]
                `FHAS_IDX_LIMIT_LOC:   limit_r[1] <= wb_dat_i[7:0]; // [RULE1]
                `FHAS_IDX_LIMIT_R2:    limit_r[2] <= wb_dat_i[7:0]; // [RULE1]
                `FHAS_IDX_HYST_R1_LOC: begin
                    hyst_r[0] <= hyst_fix(wb_dat_i[7:4]); // [RULE3]
                    hyst_r[1] <= hyst_fix(wb_dat_i[3:0]); // [RULE3]
                end
                `FHAS_IDX_HYST_R2:     hyst_r[2] <= hyst_fix(wb_dat_i[7:4]); // [RULE4]
                default: ;
            endcase
        end
    end

    // Read mux; unmapped indices read zero but still ack
    reg [7:0] rd_w;

    always @* begin
        case (idx_w)
            `FHAS_IDX_ACOU_ONE:    rd_w = acou_one_r;
            `FHAS_IDX_ACOU_TWO:    rd_w = acou_two_r;
            `FHAS_IDX_FLOOR_A:     rd_w = floor_r[0];
            `FHAS_IDX_FLOOR_B:     rd_w = floor_r[1];
            `FHAS_IDX_FLOOR_C:     rd_w = floor_r[2];
            `FHAS_IDX_LIMIT_R1:    rd_w = limit_r[0];
            `FHAS_IDX_LIMIT_LOC:   rd_w = limit_r[1];
            `FHAS_IDX_LIMIT_R2:    rd_w = limit_r[2];
            `FHAS_IDX_HYST_R1_LOC: rd_w = {hyst_r[0], hyst_r[1]}; // [RULE3]
            `FHAS_IDX_HYST_R2:     rd_w = {hyst_r[2], 4'h0};      // [RULE4]
            `FHAS_IDX_STATUS:      rd_w = {4'h0, on_r, overtemp_o};
            `FHAS_IDX_DUTY_A:      rd_w = duty_r[0];
            `FHAS_IDX_DUTY_B:      rd_w = duty_r[1];
            `FHAS_IDX_DUTY_C:      rd_w = duty_r[2];
            default:               rd_w = 8'h00;
        endcase
    end

    // Ack and read data registered together, ack drops next cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req_w;
            if (req_w) begin
                wb_dat_o <= {24'h000000, rd_w};
            end
        end
    end

endmodule // fhas_core

`default_nettype wire

// [sim/fhas_core_sva.sv]
// Port checker for the fan hysteresis and slew block
`default_nettype none
module fhas_core_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        update_i,
    input wire logic [7:0]  fan_output_a_o,
    input wire logic [7:0]  fan_output_b_o,
    input wire logic [7:0]  fan_output_c_o,
    input wire logic        overtemp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req_w = wb_cyc_i && wb_stb_i;
    wire [23:0] duty_w = {fan_output_a_o, fan_output_b_o, fan_output_c_o};
    // Bus handshake: one ack per request, one cycle long
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_resp_a: assert property (req_w && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in the next cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req_w))
        else $error("ack without a request");
    dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    // Duty and override only move on an update interval
    duty_hold_a: assert property (!update_i |=> $stable(duty_w) && $stable(overtemp_o))
        else $error("duty changed without an update");
    ot_full_a: assert property (overtemp_o |-> duty_w == 24'hFFFFFF)
        else $error("override active but duty not full");
    ot_rise_a: assert property ($rose(overtemp_o) |-> $past(update_i))
        else $error("override set outside an update");
    ot_fall_a: assert property ($fell(overtemp_o) |-> $past(update_i, 1))
        else $error("override cleared outside an update");
    // Main scenarios reached
    cover property ($rose(overtemp_o));
    cover property (req_w ##1 wb_ack_o);
    cover property (update_i ##1 $changed(fan_output_a_o));
endmodule // fhas_core_sva

bind fhas_core fhas_core_sva i_fhas_core_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .update_i(update_i), .fan_output_a_o(fan_output_a_o), .fan_output_b_o(fan_output_b_o),
    .fan_output_c_o(fan_output_c_o), .overtemp_o(overtemp_o));
`default_nettype wire

// [sim/fhas_fan_model.sv]
// Behavioural fans on the three applied duty outputs
`default_nettype none
module fhas_fan_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] duty_a_i,
    input  wire logic [7:0] duty_b_i,
    input  wire logic [7:0] duty_c_i,
    output var  logic [2:0] spin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A fan spins while any drive is applied; zero duty lets it stop
    always @(posedge clk_i) begin
        spin_o <= {duty_c_i != 8'h00, duty_b_i != 8'h00, duty_a_i != 8'h00};
    end
endmodule // fhas_fan_model
`default_nettype wire

// [sim/fan_hysteresis_acoustic_slew_test.sv]
// Self-checking bench for the fan hysteresis and slew block
`include "fhas_regs.vh"
`default_nettype none
module fan_hysteresis_acoustic_slew_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, update_i, wb_ack_o, overtemp_o;
    logic [8:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0]  temp_r1_i, temp_loc_i, temp_r2_i, tmin_i, tgt_a, tgt_b, tgt_c;
    logic [7:0]  out_a, out_b, out_c;
    logic [7:0]  steps [0:7];
    logic [2:0]  spin;
    logic [1:0]  chan_a, chan_b, chan_c;
    int          miscompares, comparisons, cycles;

    fhas_core i_fhas_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .temp_r1_i(temp_r1_i),
        .temp_loc_i(temp_loc_i), .temp_r2_i(temp_r2_i), .tmin_r1_i(tmin_i), .tmin_loc_i(tmin_i),
        .tmin_r2_i(tmin_i), .chan_a_i(chan_a), .chan_b_i(chan_b), .chan_c_i(chan_c),
        .target_a_i(tgt_a), .target_b_i(tgt_b), .target_c_i(tgt_c), .update_i(update_i),
        .fan_output_a_o(out_a), .fan_output_b_o(out_b), .fan_output_c_o(out_c),
        .overtemp_o(overtemp_o));
    fhas_fan_model i_fhas_fan_model (.clk_i(clk_i), .duty_a_i(out_a), .duty_b_i(out_b),
        .duty_c_i(out_c), .spin_o(spin));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [6:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rchk(input logic [6:0] idx, input logic [7:0] exp, input string what);
        wb(1'b0, idx, 8'h00);
        chk(what, rd, {24'h000000, exp});
    endtask
    // One update interval; outputs are judged half a cycle after it lands
    task automatic upd(input logic [7:0] t, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] c);
        @(posedge clk_i);
        temp_r1_i <= t;
        {tgt_a, tgt_b, tgt_c} <= {a, b, c};
        update_i <= 1'b1;
        @(posedge clk_i);
        update_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic dchk(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        chk("duty abc", {8'h00, out_a, out_b, out_c}, {8'h00, a, b, c});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rchk(`FHAS_IDX_LIMIT_R1, 8'h64, "limit r1");
        rchk(`FHAS_IDX_LIMIT_LOC, 8'h64, "limit loc");
        rchk(`FHAS_IDX_LIMIT_R2, 8'h64, "limit r2");
        rchk(`FHAS_IDX_HYST_R1_LOC, 8'h44, "hyst r1 loc");
        rchk(`FHAS_IDX_HYST_R2, 8'h40, "hyst r2");
        rchk(7'h7F, 8'h00, "unmapped");
        wb(1'b1, `FHAS_IDX_HYST_R2, 8'hF0);
        rchk(`FHAS_IDX_HYST_R2, 8'hF0, "hyst r2 max");
    endtask
    // Floor keep bits against plain off, default hysteresis of 4
    task automatic t_keep;
        wb(1'b1, `FHAS_IDX_ACOU_ONE, 8'hA0);
        upd(8'h3C, 8'h64, 8'h6E, 8'h78);
        dchk(8'h64, 8'h6E, 8'h78);
        upd(8'h31, 8'h64, 8'h6E, 8'h78);
        dchk(8'h80, 8'h6E, 8'h80);
        upd(8'h2E, 8'h64, 8'h6E, 8'h78);
        dchk(8'h80, 8'h00, 8'h80);
        wb(1'b1, `FHAS_IDX_ACOU_ONE, 8'h40);
        upd(8'h2E, 8'h64, 8'h6E, 8'h78);
        dchk(8'h00, 8'h80, 8'h00);
        upd(8'h32, 8'h64, 8'h6E, 8'h78);
        dchk(8'h00, 8'h80, 8'h00);
        chk("fans spinning", {29'h0, spin}, 32'h00000002);
        upd(8'h33, 8'h64, 8'h6E, 8'h78);
        dchk(8'h64, 8'h6E, 8'h78);
    endtask
    // Widest hysteresis on remote 1, then a zero write
    task automatic fan_off_hysteresis;
        wb(1'b1, `FHAS_IDX_ACOU_ONE, 8'h00);
        wb(1'b1, `FHAS_IDX_HYST_R1_LOC, 8'hF1);
        rchk(`FHAS_IDX_HYST_R1_LOC, 8'hF1, "hyst r1 loc");
        upd(8'h28, 8'h64, 8'h6E, 8'h78);
        dchk(8'h64, 8'h6E, 8'h78);
        upd(8'h23, 8'h64, 8'h6E, 8'h78);
        dchk(8'h00, 8'h00, 8'h00);
        wb(1'b1, `FHAS_IDX_HYST_R1_LOC, 8'h00);
        rchk(`FHAS_IDX_HYST_R1_LOC, 8'h11, "hyst floor");
    endtask
    // Every step code on a and b; c shares the channel but is not slewed
    task automatic t_slew;
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, `FHAS_IDX_ACOU_ONE, 8'h00);
            wb(1'b1, `FHAS_IDX_ACOU_TWO, 8'h00);
            upd(8'h3C, 8'h00, 8'h00, 8'h00);
            dchk(8'h00, 8'h00, 8'h00);
            wb(1'b1, `FHAS_IDX_ACOU_ONE, {5'h01, k[2:0]});
            wb(1'b1, `FHAS_IDX_ACOU_TWO, {1'b1, k[2:0], 4'h0});
            upd(8'h3C, 8'hC8, 8'hC8, 8'hC8);
            dchk(steps[k], steps[k], 8'hC8);
            upd(8'h3C, 8'hC8, 8'hC8, 8'hC8);
            dchk(steps[k] << 1, steps[k] << 1, 8'hC8);
            upd(8'h3C, 8'h00, 8'h00, 8'h00);
            dchk(steps[k], steps[k], 8'h00);
        end
    endtask
    // Local channel trips its lowered limit; release needs more than 4 below it
    task automatic t_ot;
        wb(1'b1, `FHAS_IDX_ACOU_ONE, 8'h00);
        wb(1'b1, `FHAS_IDX_ACOU_TWO, 8'h00);
        wb(1'b1, `FHAS_IDX_LIMIT_LOC, 8'h46);
        temp_loc_i <= 8'h47;
        upd(8'h3C, 8'h1E, 8'h28, 8'h32);
        dchk(8'hFF, 8'hFF, 8'hFF);
        chk("overtemp pin", {31'h0, overtemp_o}, 32'h00000001);
        rchk(`FHAS_IDX_STATUS, 8'h0F, "status");
        temp_loc_i <= 8'h43;
        upd(8'h3C, 8'h1E, 8'h28, 8'h32);
        dchk(8'hFF, 8'hFF, 8'hFF);
        temp_loc_i <= 8'h41;
        upd(8'h3C, 8'h1E, 8'h28, 8'h32);
        dchk(8'h1E, 8'h28, 8'h32);
        chk("overtemp pin", {31'h0, overtemp_o}, 32'h00000000);
    endtask
    // Each output follows its own channel: a remote 1, b local, c remote 2
    task automatic t_chan;
        wb(1'b1, `FHAS_IDX_HYST_R1_LOC, 8'h28);
        wb(1'b1, `FHAS_IDX_LIMIT_LOC, 8'h64);
        {chan_a, chan_b, chan_c} <= 6'h06;
        {temp_loc_i, temp_r2_i} <= 16'h3C3C;
        upd(8'h3C, 8'h1E, 8'h28, 8'h32);
        dchk(8'h1E, 8'h28, 8'h32);
        @(posedge clk_i);
        {temp_loc_i, temp_r2_i} <= 16'h2E2E;
        upd(8'h2E, 8'h1E, 8'h28, 8'h32);
        dchk(8'h00, 8'h28, 8'h32);
        @(posedge clk_i);
        {temp_loc_i, temp_r2_i} <= 16'h2A2A;
        upd(8'h2A, 8'h1E, 8'h28, 8'h32);
        dchk(8'h00, 8'h00, 8'h32);
        rchk(`FHAS_IDX_DUTY_C, 8'h32, "duty c readback");
        rchk(`FHAS_IDX_STATUS, 8'h08, "status chan");
        temp_r2_i <= 8'h23;
        upd(8'h2A, 8'h1E, 8'h28, 8'h32);
        dchk(8'h00, 8'h00, 8'h00);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Clock at 25 MHz
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test;
        end
    end
    // Main sequence
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, update_i} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {9'h000, 4'hF, 32'h00000000};
        {temp_r1_i, temp_loc_i, temp_r2_i, tmin_i} = {8'h14, 8'h14, 8'h14, 8'h32};
        {tgt_a, tgt_b, tgt_c} = 24'h000000;
        {chan_a, chan_b, chan_c} = 6'h00;
        steps = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_keep;
        fan_off_hysteresis;
        t_slew;
        t_ot;
        t_chan;
        end_of_test;
    end
endmodule // fan_hysteresis_acoustic_slew_test
`default_nettype wire
